/* esw_defs.svh */
// Constants for the status and write-protect block: bit positions,
// opcodes, reset values and guarded address bounds.
// Assumes nothing; included by the package, the link file and the top file.
`ifndef ESW_DEFS_SVH
`define ESW_DEFS_SVH
// Status word bit positions
`define ESW_BIT_BUSY   0
`define ESW_BIT_WEL    1
`define ESW_BIT_BP_LO  2
`define ESW_BIT_BP_HI  3
`define ESW_BIT_ARM    7
// Opcode layout: upper nibble fixed, bit 3 ignored, low three bits select
`define ESW_OP_HI      4'h0
`define ESW_OP_SETWL   3'h6
`define ESW_OP_CLRWL   3'h4
`define ESW_OP_FETCH   3'h5
`define ESW_OP_STORE   3'h1
// Whole-byte counts a well-formed frame carries
`define ESW_NB_CMD     2'h1
`define ESW_NB_STORE   2'h2
// Reset and view values
`define ESW_BP_RESET   2'h0
`define ESW_ARM_RESET  1'h0
`define ESW_BUSY_VIEW  8'hFF
// Lower bounds of the guarded ranges, all ending at the top address
`define ESW_GUARD_Q    13'h1800
`define ESW_GUARD_H    13'h1000
`endif

/* esw_pkg.sv */
// Types and shared decode functions of the status/write-protect block.
// Assumes esw_defs.svh is on the include path.
package esw_pkg;
  `include "esw_defs.svh"

  // Programming sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_PROG_STATUS, ST_PROG_ARRAY} esw_state_e;

  // What the link captured in the last frame
  typedef struct packed {
    logic [7:0] op;      // First byte
    logic [7:0] dat;     // Second byte
    logic [1:0] nbytes;  // Whole bytes seen, saturating
    logic       id;      // Flips once per clocked frame
  } esw_frame_s;

  // Retained guard settings
  typedef struct packed {
    logic       arm;     // Pin guard armed
    logic [1:0] bp;      // Guard level hi, lo
  } esw_guard_s;

  // Opcode match, bit 3 ignored
  function automatic logic esw_is_cmd(input logic [7:0] op, input logic [2:0] code);
    return (op[7:4] == `ESW_OP_HI) && (op[2:0] == code);
  endfunction : esw_is_cmd

  // Guarded range decode of the level pair
  function automatic logic esw_in_guard(input logic [1:0] bp, input logic [12:0] addr);
    case (bp)
      2'h1:    return addr >= `ESW_GUARD_Q;
      2'h2:    return addr >= `ESW_GUARD_H;
      2'h3:    return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : esw_in_guard
endpackage : esw_pkg

/* esw_sync.sv */
// Two-stage level synchroniser into the core clock.
// Assumes inputs are levels held far longer than two clocks.
module esw_sync #(
  parameter int W = 1
) (
  // Clock, enable, reset
  input  wire logic         clk,
  input  wire logic         ce,
  input  wire logic         reset,
  // Asynchronous level in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;       // First stage, read only by q
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // Freeze both stages while the enable is low
  always_comb begin
    next_meta = ce ? d : meta;
    next_q    = ce ? meta : q;
  end

  // Stage registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule : esw_sync

/* esw_link.sv */
// Serial front end on the link clock: shifts in opcode and data, shifts
// out the status word, honours the suspend pin.
// Assumes suspend changes only while the link clock is low, and that the
// published status word stays still while chip select is low.
`include "esw_defs.svh"
module esw_link (
  // Link clock and frame pins
  input  wire logic               sck,
  input  wire logic               cs_n,
  input  wire logic               hold_n,
  input  wire logic               si,
  // Core side
  input  wire logic               reset,
  input  wire logic [7:0]         status_pub,
  output esw_pkg::esw_frame_s     frame,
  // Serial output pin
  output logic                    so_out,
  output logic                    so_oe
);
  logic [2:0]          bitcnt;      // Bit within the byte
  logic [2:0]          next_bitcnt;
  logic                fresh;       // No edge yet in this frame
  logic                next_fresh;
  logic [6:0]          shreg;       // Bits of the byte so far
  logic [6:0]          next_shreg;
  esw_pkg::esw_frame_s next_frame;
  logic [1:0]          base;        // Byte count this frame
  logic [7:0]          byte_in;
  logic                next_so;
  logic                next_oe;
  logic                frame_off;   // Ends bit state with the frame
  logic                so_off;      // Floats the output

  assign frame_off = reset | cs_n;
  assign so_off    = frame_off | ~hold_n;

  // Next shift state; a held edge changes nothing
  always_comb begin
    byte_in     = {shreg, si};
    base        = fresh ? 2'h0 : frame.nbytes;
    next_bitcnt = bitcnt;
    next_fresh  = fresh;
    next_shreg  = shreg;
    next_frame  = frame;
    if (hold_n) begin
      next_bitcnt       = bitcnt + 3'h1;
      next_fresh        = 1'b0;
      next_shreg        = byte_in[6:0];
      next_frame.nbytes = base;
      if (fresh) begin
        next_frame.id = ~frame.id;
      end
      if (bitcnt == 3'h7) begin
        if (base == 2'h0) begin
          next_frame.op = byte_in;
        end else if (base == 2'h1) begin
          next_frame.dat = byte_in;
        end
        if (base != 2'h3) begin
          next_frame.nbytes = base + 2'h1;
        end
      end
    end
    // Status repeats every byte after a fetch opcode, MSB first
    next_oe = !fresh && (frame.nbytes != 2'h0) && esw_pkg::esw_is_cmd(frame.op, `ESW_OP_FETCH);
    next_so = status_pub[3'h7 - bitcnt];
  end

  // Bit position restarts with every frame
  always_ff @(posedge sck or posedge frame_off) begin
    if (frame_off) begin
      bitcnt <= 3'h0;
      fresh  <= 1'b1;
    end else begin
      bitcnt <= next_bitcnt;
      fresh  <= next_fresh;
    end
  end

  // Captured bytes outlive the frame so the core can read them after it
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      shreg <= 7'h00;
      frame <= '0;
    end else begin
      shreg <= next_shreg;
      frame <= next_frame;
    end
  end

  // Data bit launched on the falling edge; kept through a suspend so so_out
  // still holds the paused bit at release, but so_oe stays low until the next falling edge
  always_ff @(negedge sck or posedge frame_off) begin
    if (frame_off) begin
      so_out <= 1'b0;
    end else begin
      so_out <= next_so;
    end
  end

  // Enable floats outside frames and while suspended
  always_ff @(negedge sck or posedge so_off) begin
    if (so_off) begin
      so_oe <= 1'b0;
    end else begin
      so_oe <= next_oe;
    end
  end
endmodule : esw_link

/* esw_top.sv */
// Status word and write-protect core of a serial EEPROM, with the serial
// link front end. Assumes the array sequencer and programming engine sit
// outside and talk over the request, start and done strobes.
`include "esw_defs.svh"
module esw_top (
  // Core clock, enable, reset
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        reset,
  // Serial link pins
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic        hold_n,
  output logic             so_out,
  output logic             so_oe,
  // Protect pin
  input  wire logic        wp_n,
  // Array sequencer side
  input  wire logic        array_wr_req,
  input  wire logic [12:0] array_wr_addr,
  output logic             array_wr_grant,
  // Programming engine side
  output logic             prog_start,
  input  wire logic        prog_done,
  // Status view
  output logic [7:0]       status_word,
  output logic             hw_guard
);
  esw_pkg::esw_frame_s frame;        // Link capture, read after cs rises
  esw_pkg::esw_guard_s guard;        // Retained levels and arm
  esw_pkg::esw_guard_s next_guard;
  esw_pkg::esw_guard_s pend;         // Store value awaiting done
  esw_pkg::esw_guard_s next_pend;
  esw_pkg::esw_state_e st;
  esw_pkg::esw_state_e next_st;
  logic       wel;                   // Write-enable latch
  logic       next_wel;
  logic       id_seen;               // Last frame id acted on
  logic       next_id_seen;
  logic [7:0] status_pub;            // Copy seen by the link
  logic [7:0] next_pub;
  logic [7:0] view;
  logic       next_grant;
  logic       next_start;
  logic       next_hw_guard;
  logic       cs_s;                  // Chip select, synchronised
  logic       wp_s;                  // Protect pin, synchronised
  logic       id_s;                  // Frame id, synchronised
  logic       exec;                  // A new frame just ended
  logic       busy;
  logic       hw_prot;
  logic       cmd_set;
  logic       cmd_clr;
  logic       cmd_store;
  logic       in_guard;
  logic       grant;

  // Front end on the link clock
  esw_link u_link (
    .sck        (sck),
    .cs_n       (cs_n),
    .hold_n     (hold_n),
    .si         (si),
    .reset      (reset),
    .status_pub (status_pub),
    .frame      (frame),
    .so_out     (so_out),
    .so_oe      (so_oe)
  );

  // Pins and frame id into the core clock; bytes are read only once
  // the synchronised id shows a new frame and synchronised chip select has risen, so they are stable
  esw_sync #(.W(3)) u_sync (
    .clk   (clk),
    .ce    (ce),
    .reset (reset),
    .d     ({cs_n, wp_n, frame.id}),
    .q     ({cs_s, wp_s, id_s})
  );

  // Command decode and protection checks
  always_comb begin
    busy      = (st != esw_pkg::ST_IDLE);
    hw_prot   = !wp_s && guard.arm;
    exec      = cs_s && (id_s != id_seen);
    cmd_set   = exec && !busy && (frame.nbytes == `ESW_NB_CMD)
                && esw_pkg::esw_is_cmd(frame.op, `ESW_OP_SETWL);
    cmd_clr   = exec && !busy && (frame.nbytes == `ESW_NB_CMD)
                && esw_pkg::esw_is_cmd(frame.op, `ESW_OP_CLRWL);
    // Store refused under the pin guard, so arm cannot drop with pin low
    cmd_store = exec && !busy && wel && !hw_prot
                && (frame.nbytes == `ESW_NB_STORE)
                && esw_pkg::esw_is_cmd(frame.op, `ESW_OP_STORE);
    in_guard  = esw_pkg::esw_in_guard(guard.bp, array_wr_addr);
    // Array path ignores the pin guard; a link store command takes priority
    grant     = array_wr_req && !busy && !cmd_store && wel && !in_guard;
  end

  // Sequencer, latch and retained settings
  always_comb begin
    next_st      = st;
    next_wel     = wel;
    next_guard   = guard;
    next_pend    = pend;
    next_id_seen = exec ? id_s : id_seen;
    next_start   = cmd_store || grant;
    next_grant   = grant;
    if (cmd_set) begin
      next_wel = 1'b1;
    end
    if (cmd_clr) begin
      next_wel = 1'b0;
    end
    case (st)
      esw_pkg::ST_IDLE: begin
        if (cmd_store) begin
          next_pend.arm = frame.dat[`ESW_BIT_ARM];
          next_pend.bp  = frame.dat[`ESW_BIT_BP_HI:`ESW_BIT_BP_LO];
          next_st       = esw_pkg::ST_PROG_STATUS;
        end else if (grant) begin
          next_st = esw_pkg::ST_PROG_ARRAY;
        end
      end
      esw_pkg::ST_PROG_STATUS: begin
        if (prog_done) begin
          next_guard = pend;
          next_wel   = 1'b0;
          next_st    = esw_pkg::ST_IDLE;
        end
      end
      esw_pkg::ST_PROG_ARRAY: begin
        if (prog_done) begin
          next_wel = 1'b0;
          next_st  = esw_pkg::ST_IDLE;
        end
      end
      default: begin
        next_st = esw_pkg::ST_IDLE;
      end
    endcase
  end

  // Status view; the link copy only moves while no frame is open
  always_comb begin
    view               = {guard.arm, 3'h0, guard.bp, wel, 1'b0};
    if (busy) begin
      view = `ESW_BUSY_VIEW;
    end
    next_pub           = cs_s ? view : status_pub;
    next_hw_guard      = hw_prot;
  end

  // Core registers, frozen while the enable is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st             <= esw_pkg::ST_IDLE;
      wel            <= 1'b0;
      guard          <= {`ESW_ARM_RESET, `ESW_BP_RESET};
      pend           <= {`ESW_ARM_RESET, `ESW_BP_RESET};
      id_seen        <= 1'b0;
      status_pub     <= 8'h00;
      status_word    <= 8'h00;
      array_wr_grant <= 1'b0;
      prog_start     <= 1'b0;
      hw_guard       <= 1'b0;
    end else if (ce) begin
      st             <= next_st;
      wel            <= next_wel;
      guard          <= next_guard;
      pend           <= next_pend;
      id_seen        <= next_id_seen;
      status_pub     <= next_pub;
      status_word    <= view;
      array_wr_grant <= next_grant;
      prog_start     <= next_start;
      hw_guard       <= next_hw_guard;
    end
  end

  // Checks on the core clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);

  sequence s_done;
    busy && prog_done;
  endsequence

  sequence s_store_req;
    exec && !busy && (frame.nbytes == `ESW_NB_STORE) && esw_pkg::esw_is_cmd(frame.op, `ESW_OP_STORE);
  endsequence

  property p_guard_blocks_store;
    s_store_req ##0 (hw_prot || !wel) |=> st == esw_pkg::ST_IDLE && !prog_start;
  endproperty
  a_guard_blocks_store: assert property (p_guard_blocks_store) else $error("store taken while refused");

  property p_store_starts;
    s_store_req ##0 (wel && !hw_prot) |=> st == esw_pkg::ST_PROG_STATUS && prog_start;
  endproperty
  a_store_starts: assert property (p_store_starts) else $error("valid store not started");

  property p_arm_kept;
    s_store_req ##0 (guard.arm && !wp_s) |=> guard.arm [*2];
  endproperty
  a_arm_kept: assert property (p_arm_kept) else $error("arm dropped with pin low");

  property p_busy_view;
    busy |=> status_word == `ESW_BUSY_VIEW;
  endproperty
  a_busy_view: assert property (p_busy_view) else $error("busy word not all ones");

  property p_idle_spare;
    !busy |=> status_word[6:4] == 3'h0 && !status_word[`ESW_BIT_BUSY];
  endproperty
  a_idle_spare: assert property (p_idle_spare) else $error("idle spare bits not zero");

  property p_set_latch;
    exec && !busy && (frame.nbytes == `ESW_NB_CMD) && esw_pkg::esw_is_cmd(frame.op, `ESW_OP_SETWL) |=> wel;
  endproperty
  a_set_latch: assert property (p_set_latch) else $error("latch not set");

  property p_busy_ignores;
    busy && exec && !prog_done |=> wel == $past(wel) && $stable(guard);
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("command obeyed while busy");

  property p_done_clears;
    s_done |=> !wel && !busy;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("latch kept after programming");

  property p_hold_values;
    busy && !prog_done |=> $stable(guard);
  endproperty
  a_hold_values: assert property (p_hold_values) else $error("guard moved before done");

  property p_guarded_refused;
    array_wr_req && in_guard |=> !array_wr_grant;
  endproperty
  a_guarded_refused: assert property (p_guarded_refused) else $error("guarded address granted");

  property p_pin_no_array_effect;
    array_wr_req && !busy && !exec && wel && !in_guard && hw_prot |=> array_wr_grant ##1 busy;
  endproperty
  a_pin_no_array_effect: assert property (p_pin_no_array_effect) else $error("pin guard blocked array");

  sequence s_status_done;
    (st == esw_pkg::ST_PROG_STATUS) && prog_done;
  endsequence

  // Stored settings land only as the status program ends
  property p_store_applied;
    s_status_done |=> guard == $past(pend) && !busy;
  endproperty
  a_store_applied: assert property (p_store_applied) else $error("stored settings not applied");

  // Clear command drops the latch
  property p_clear_latch;
    exec && !busy && (frame.nbytes == `ESW_NB_CMD) && esw_pkg::esw_is_cmd(frame.op, `ESW_OP_CLRWL) |=> !wel;
  endproperty
  a_clear_latch: assert property (p_clear_latch) else $error("latch not cleared");

  // Pin guard flag follows pin and arm one cycle later
  property p_guard_flag_on;
    !wp_s && guard.arm |=> hw_guard;
  endproperty
  a_guard_flag_on: assert property (p_guard_flag_on) else $error("pin guard flag missing");

  property p_guard_flag_off;
    wp_s || !guard.arm |=> !hw_guard;
  endproperty
  a_guard_flag_off: assert property (p_guard_flag_off) else $error("pin guard flag stuck");

  // A clear latch keeps the whole array closed
  property p_latch_blocks_array;
    array_wr_req && !wel |=> !array_wr_grant && !prog_start;
  endproperty
  a_latch_blocks_array: assert property (p_latch_blocks_array) else $error("array granted with latch clear");
endmodule : esw_top

/* esw_master.sv */
// Behavioural serial bus master driving the link pins of the status block.
// Assumes mode 0 framing, MSB first, and a caller that spaces frames itself.
module esw_master (
  // Link pins driven toward the device
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  // Serial output pin of the device
  input  wire logic so_out,
  input  wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: clock parked low, suspend released until a frame asks for one
  initial begin
    sck    = 1'b0;
    cs_n   = 1'b1;
    si     = 1'b1;
    hold_n = 1'b1;
  end

  // One frame; an optional suspend before bit hold_at, with junk clocks in it
  task automatic xfer(input logic [15:0] tx, input int nbits, input int hold_at, input int skew,
                      output logic [7:0] rx, output logic held);
    rx   = 8'h00;
    held = 1'b0;
    #(skew);
    cs_n = 1'b0;
    #200;
    for (int i = 0; i < nbits; i++) begin
      // Suspend moved only while the clock is low
      if (i == hold_at) begin
        #20 hold_n = 1'b0;
        repeat (2) begin
          si = ~si;
          #40 sck = 1'b1;
          held = held | so_oe;
          #40 sck = 1'b0;
        end
        #40 hold_n = 1'b1;
        #40;
      end
      si = tx[15-i];
      #40 sck = 1'b1;
      rx = {rx[6:0], so_out};
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    // Released data line must not keep the last bit
    si = ~si;
    #240;
  endtask : xfer
endmodule : esw_master

/* esw_top_tb_top.sv */
// Self-checking bench of the status/write-protect core with a serial master.
// Assumes esw_pkg, esw_master and the design files are compiled first.
module esw_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Core side signals
  logic        clk, ce, reset, wp_n, hw_guard;
  logic        array_wr_req, array_wr_grant, prog_start, prog_done;
  logic [12:0] array_wr_addr;
  logic [7:0]  status_word, rx;
  // Link pins
  logic        sck, cs_n, si, hold_n, so_out, so_oe, held;
  // Counters and reference model state
  int          error_cnt, n_checks;
  int          wel, bp, arm, busy;
  int          pend_q[$];             // Store values awaiting done
  logic [31:0] seed;
  logic [12:0] bnd [6] = '{13'h17FF, 13'h1800, 13'h0FFF, 13'h1000, 13'h0000, 13'h1FFF};

  esw_top dut (
    .clk(clk), .ce(ce), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .so_out(so_out), .so_oe(so_oe), .wp_n(wp_n), .array_wr_req(array_wr_req),
    .array_wr_addr(array_wr_addr), .array_wr_grant(array_wr_grant), .prog_start(prog_start),
    .prog_done(prog_done), .status_word(status_word), .hw_guard(hw_guard)
  );

  esw_master bfm (
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe)
  );

  // Core clock, 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Fixed-seed xorshift
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Expected status view
  function automatic logic [7:0] exp_sw();
    return busy ? 8'hFF : {arm[0], 3'h0, bp[1:0], wel[0], 1'b0};
  endfunction : exp_sw

  // Pin guard as the model sees it
  function automatic logic grd();
    return !wp_n && (arm == 1);
  endfunction : grd

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // One link frame, then the model step and a status compare
  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int nb, input int hold_at);
    bfm.xfer({op, d}, nb * 8, hold_at, int'(xs() % 29), rx, held);
    if (op == 8'h05) chk("fetched byte", exp_sw(), rx);
    if (hold_at < nb * 8) chk("so_oe in suspend", 8'h00, {7'h0, held});
    // Busy: everything but a fetch is dropped
    if (busy == 0) begin
      case (op & 8'hF7)
        8'h06: wel = 1;
        8'h04: wel = 0;
        8'h01: if (wel == 1 && !grd()) begin
          busy = 1;
          pend_q.push_back(int'(d));
        end
        default: ;
      endcase
    end
    repeat (8) @(posedge clk);
    #2;
    chk("status_word", exp_sw(), status_word);
  endtask : cmd

  // Engine finishes the running program
  task automatic done();
    int pv;
    repeat (3) @(posedge clk);
    #2 prog_done = 1'b1;
    @(posedge clk);
    #2 prog_done = 1'b0;
    if (pend_q.size() > 0) begin
      pv  = pend_q.pop_front();
      arm = pv[7];
      bp  = (pv >> 2) & 3;
    end
    wel  = 0;
    busy = 0;
    // Settle time before the status read, scaled down from the real wait
    repeat (3) @(posedge clk);
    #2;
    chk("status after done", exp_sw(), status_word);
  endtask : done

  // Array program request from the sequencer
  task automatic awr(input logic [12:0] a);
    logic g, ps, ex;
    @(posedge clk);
    #2;
    array_wr_req  = 1'b1;
    array_wr_addr = a;
    @(posedge clk);
    #1;
    g  = array_wr_grant;
    ps = prog_start;
    #1 array_wr_req = 1'b0;
    ex = (wel == 1) && (busy == 0) && !((bp == 1 && a >= 6144) || (bp == 2 && a >= 4096) || bp == 3);
    chk("array_wr_grant", {7'h0, ex}, {7'h0, g});
    chk("prog_start", {7'h0, ex}, {7'h0, ps});
    if (ex) begin
      busy = 1;
      done();
    end
  endtask : awr

  // Protect pin change, let the two-flop sync settle
  task automatic set_wp(input logic v);
    wp_n = v;
    repeat (4) @(posedge clk);
    #2;
    chk("hw_guard", {7'h0, grd()}, {7'h0, hw_guard});
  endtask : set_wp

  // Hang guard
  initial begin
    #1000000;
    error_cnt++;
    close_out();
  end

  // Main sequence
  initial begin
    ce = 1'b1;
    reset = 1'b1;
    wp_n = 1'b1;
    array_wr_req = 1'b0;
    array_wr_addr = 13'h0000;
    prog_done = 1'b0;
    seed = 32'h4997;
    error_cnt = 0;
    n_checks = 0;
    wel = 0;
    bp = 0;
    arm = 0;
    busy = 0;
    repeat (3) @(posedge clk);
    #2 reset = 1'b0;
    repeat (3) @(posedge clk);
    #2;
    chk("status after reset", 8'h00, status_word);
    cmd(8'h05, 8'h00, 2, 99);
    cmd(8'h01, 8'h8C, 2, 99);
    awr(13'h0000);
    cmd(8'h0E, 8'h00, 1, 3);
    cmd(8'h01, (xs() & 8'h73) | 8'h8C, 2, 99);
    cmd(8'h05, 8'h00, 2, 11);
    cmd(8'h04, 8'h00, 1, 99);
    awr(13'h0000);
    done();
    cmd(8'h05, 8'h00, 2, 99);
    set_wp(1'b0);
    cmd(8'h06, 8'h00, 1, 99);
    cmd(8'h01, 8'h00, 2, 99);
    // Every guard level, boundary and random addresses, pin guard active
    for (int lvl = 0; lvl < 4; lvl++) begin
      set_wp(1'b1);
      cmd(8'h06, 8'h00, 1, 99);
      cmd(8'h01, (xs() & 8'h73) | 8'h80 | 8'(lvl << 2), 2, 99);
      done();
      set_wp(1'b0);
      for (int k = 0; k < 7; k++) begin
        cmd(8'h06, 8'h00, 1, 99);
        awr(k < 6 ? bnd[k] : 13'(xs()));
      end
    end
    // Enable low freezes the core: the guard flag keeps its old value
    ce = 1'b0;
    wp_n = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    chk("hw_guard frozen", 8'h01, {7'h0, hw_guard});
    ce = 1'b1;
    set_wp(1'b1);
    cmd(8'h04, 8'h00, 1, 99);
    awr(13'h0400);
    close_out();
  end
endmodule : esw_top_tb_top
